// >>> atc_map.svh
// Register indices, field positions, reset values for the trigger/flag block.
// Assumes an APB slave with byte address = 4 * register index.
//
// Contract
// RULE1: fast clear off: a completion flag clears only by writing one to it.
// RULE2: fast clear on, compare off: reading result n clears flag n.
// RULE3: fast clear on, compare on: writing result n clears flag n.
// RULE4: trigger sense from level/edge and polarity: fall, rise, low, high.
// RULE5: trigger enable syncs start to selected channel or trigger input.
// RULE6: sequence irq enabled requests interrupt while sequence done is set.
// RULE7: compare irq enabled requests interrupt on any compare channel flag.
// RULE8: sequence done flag, status bit 7, sets on each completed sequence.
// RULE9: sequence done clears by write one, control five write, fast read.
// RULE10: edge mode: extra trigger edge during a sequence sets bit 5.
// RULE11: overrun flags clear by write one, abort writes, control five write.
// RULE12: result written while its completion flag is set sets bit 4.
// RULE13: status zero always accessible; writes keep the conversion counter.
// RULE14: software keeps the reserved control two bit at its reset value.
// RULE15: writing zero to any write-one-to-clear flag changes nothing.
`ifndef ATC_MAP_SVH
`define ATC_MAP_SVH
`define ATC_IDX_CTL0 6'h00
`define ATC_IDX_CTL1 6'h01
`define ATC_IDX_CTL2 6'h02
`define ATC_IDX_CTL4 6'h04
`define ATC_IDX_CTL5 6'h05
`define ATC_IDX_STAT0 6'h06
`define ATC_IDX_COMPARE_ENABLE 6'h08
`define ATC_IDX_CMPHT 6'h09
`define ATC_IDX_CCF 6'h0B
`define ATC_IDX_IRQS 6'h0C
`define ATC_IDX_IRQM 6'h0D
`define ATC_IDX_RES 6'h10
`define ATC_RES_MASK 6'h38
`define ATC_CTL2_FFC 6
`define ATC_CTL2_LE 4
`define ATC_CTL2_POL 3
`define ATC_CTL2_ETE 2
`define ATC_CTL2_SIE 1
`define ATC_CTL2_CIE 0
`define ATC_CTL2_WMASK 8'h7F
`define ATC_ST_SCF 7
`define ATC_ST_TOR 5
`define ATC_ST_ROR 4
`define ATC_CTL_RST 8'h00
`define ATC_IRQM_RST 4'hF
`define ATC_NUM_SRC 4'hC
`define ATC_NUM_AIN 4'h8
`endif

// >>> atc_pkg.sv
// Types shared by the trigger/flag control block.
// Assumes the converter delivers results on the same clock.
package atc_pkg;
  typedef struct packed {
    logic valid;
    logic cmp_hit;
    logic [2:0] idx;
    logic [15:0] data;
  } atc_res_s;
  typedef enum logic {ST_IDLE, ST_BUSY} atc_seq_e;
endpackage

// >>> atc_core.sv
// Converter sequencer control: flags, trigger, interrupts, APB registers.
// Assumes the converter reports results and sequence end on clk.
`timescale 1ns/10ps
`default_nettype none
`include "atc_map.svh"
module atc_core
  import atc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] trigger_inputs,
  input wire logic [7:0] ain_digital,
  input wire atc_res_s conv_result,
  input wire logic seq_done,
  output logic conv_start,
  output logic conv_abort,
  output logic seq_busy,
  output logic [7:0] ain_buf_en,
  output logic seq_irq_req,
  output logic cmp_irq_req,
  output logic irq
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  function automatic logic is_res(input logic [5:0] i);
    is_res = (i & `ATC_RES_MASK) == `ATC_IDX_RES;
  endfunction
  function automatic logic is_abort(input logic [5:0] i);
    is_abort = (i <= `ATC_IDX_CTL4) || (i == `ATC_IDX_COMPARE_ENABLE) ||
      (i == `ATC_IDX_CMPHT);
  endfunction
  function automatic logic is_mapped(input logic [5:0] i);
    is_mapped = (i <= `ATC_IDX_STAT0) || is_res(i) ||
      (i == `ATC_IDX_COMPARE_ENABLE) || (i == `ATC_IDX_CMPHT) ||
      (i == `ATC_IDX_CCF) || (i == `ATC_IDX_IRQS) ||
      (i == `ATC_IDX_IRQM);
  endfunction

  logic [7:0] ctl [6];
  logic [7:0] next_ctl [6];
  logic [15:0] res [8];
  logic [15:0] next_res [8];
  logic [7:0] compare_enable, next_compare_enable, cmpht, next_cmpht, ccf, next_ccf;
  logic sequence_done_flag, next_scf, tor, next_tor, ror, next_ror;
  logic [3:0] cc, next_cc, irqs, next_irqs, irqm, next_irqm;
  atc_seq_e state, next_state;
  logic next_start, next_abort;
  logic [7:0] next_bufen;
  logic [31:0] next_prdata, rdata;
  logic [11:0] sync1, sync2, sync3;
  logic [5:0] widx;
  logic [2:0] ridx;
  logic acc, wr, rd, wr_stat, ctl5_wr, abort_wr, rd_res, wr_res;
  logic ffc, le, pol, ete;
  logic [3:0] src;
  logic lvl_now, lvl_old, act_lvl, act_edge, trig_go;
  logic scf_set, tor_set, ror_set, ovr_clr;
  logic [7:0] ccf_set, ccf_clr;

  assign widx = paddr[7:2];
  assign ridx = paddr[4:2];
  assign pready = ce;
  assign acc = psel & penable & ce;
  assign pslverr = psel & penable & !is_mapped(widx);
  assign wr = acc & pwrite;
  assign rd = acc & !pwrite;
  assign wr_stat = wr & (widx == `ATC_IDX_STAT0);
  assign ctl5_wr = wr & (widx == `ATC_IDX_CTL5);
  assign abort_wr = wr & is_abort(widx);
  assign rd_res = rd & is_res(widx);
  assign wr_res = wr & is_res(widx);
  assign ffc = ctl[2][`ATC_CTL2_FFC];
  assign le = ctl[2][`ATC_CTL2_LE];
  assign pol = ctl[2][`ATC_CTL2_POL];
  assign ete = ctl[2][`ATC_CTL2_ETE];
  assign src = ctl[1][3:0];
  assign seq_busy = state == ST_BUSY;

  // source select: 0-7 analog channels, 8-11 trigger inputs
  always_comb
  begin
    lvl_now = 1'b0;
    lvl_old = 1'b0;
    if (src < `ATC_NUM_SRC)
    begin
      lvl_now = sync2[src];
      lvl_old = sync3[src];
    end
  end

  assign act_lvl = lvl_now == pol; // [RULE4]
  assign act_edge = (lvl_now != lvl_old) && (lvl_now == pol); // [RULE4]
  assign trig_go = ete & (le ? act_lvl : act_edge); // [RULE5]

  assign seq_irq_req = sequence_done_flag & ctl[2][`ATC_CTL2_SIE]; // [RULE6]
  assign cmp_irq_req = ctl[2][`ATC_CTL2_CIE] & |(ccf & compare_enable); // [RULE7]
  assign irq = |(irqs & irqm);

  always_comb
  begin
    rdata = 32'h0;
    if (is_res(widx))
      rdata[15:0] = res[widx[2:0]];
    else if (widx <= `ATC_IDX_CTL5)
      rdata[7:0] = ctl[widx[2:0]];
    else
      case (widx)
        `ATC_IDX_STAT0: rdata[7:0] = {sequence_done_flag, 1'b0, tor, ror, cc};
        `ATC_IDX_COMPARE_ENABLE: rdata[7:0] = compare_enable;
        `ATC_IDX_CMPHT: rdata[7:0] = cmpht;
        `ATC_IDX_CCF: rdata[7:0] = ccf;
        `ATC_IDX_IRQS: rdata[3:0] = irqs;
        `ATC_IDX_IRQM: rdata[3:0] = irqm;
        default: rdata = 32'h0;
      endcase
  end

  always_comb
  begin
    next_ctl = ctl;
    next_res = res;
    next_compare_enable = compare_enable;
    next_cmpht = cmpht;
    next_irqm = irqm;
    next_state = state;
    next_start = 1'b0;
    next_abort = 1'b0;
    next_cc = cc;
    next_prdata = (psel & !penable & !pwrite) ? rdata : prdata;
    if (wr)
    begin
      if (widx == `ATC_IDX_CTL2)
        next_ctl[2] = pwdata[7:0] & `ATC_CTL2_WMASK;
      else if (widx <= `ATC_IDX_CTL5)
        next_ctl[widx[2:0]] = pwdata[7:0];
      if (wr_res)
        next_res[ridx] = pwdata[15:0];
      if (widx == `ATC_IDX_COMPARE_ENABLE)
        next_compare_enable = pwdata[7:0];
      if (widx == `ATC_IDX_CMPHT)
        next_cmpht = pwdata[7:0];
      if (widx == `ATC_IDX_IRQM)
        next_irqm = pwdata[3:0];
    end
    // sequencing: abort beats restart beats trigger
    if (abort_wr)
    begin
      next_state = ST_IDLE;
      next_abort = 1'b1;
    end
    else if (ctl5_wr & !ete)
    begin
      next_state = ST_BUSY;
      next_start = 1'b1;
    end
    else
      case (state)
        ST_IDLE:
          if (trig_go) // [RULE5]
          begin
            next_state = ST_BUSY;
            next_start = 1'b1;
          end
        ST_BUSY:
          if (seq_done)
            next_state = ST_IDLE;
        default: next_state = ST_IDLE;
      endcase
    // counter clears on a sequence start unless a result arrives that cycle, and otherwise moves only by conversion progress
    if (next_start)
      next_cc = 4'h0; // [RULE13]
    if (conv_result.valid)
    begin
      next_res[conv_result.idx] = conv_result.data;
      next_cc = {1'b0, conv_result.idx} + 4'h1; // [RULE13]
    end
    next_bufen = 8'h00;
    if (ete && (src < `ATC_NUM_AIN))
      next_bufen = 8'h01 << src[2:0]; // [RULE5]
  end

  // flag group: every set wins over a clear in the same cycle
  always_comb
  begin
    scf_set = seq_done & (state == ST_BUSY); // [RULE8]
    next_scf = sequence_done_flag;
    if ((wr_stat & pwdata[`ATC_ST_SCF]) | ctl5_wr | (rd_res & ffc))
      next_scf = 1'b0; // [RULE9] [RULE15]
    if (scf_set)
      next_scf = 1'b1;
    ovr_clr = abort_wr | ctl5_wr; // [RULE11]
    tor_set = ete & !le & act_edge & (state == ST_BUSY); // [RULE10]
    next_tor = tor;
    if (ovr_clr | (wr_stat & pwdata[`ATC_ST_TOR]))
      next_tor = 1'b0; // [RULE11] [RULE15]
    if (tor_set)
      next_tor = 1'b1;
    ror_set = conv_result.valid & ccf[conv_result.idx]; // [RULE12]
    next_ror = ror;
    if (ovr_clr | (wr_stat & pwdata[`ATC_ST_ROR]))
      next_ror = 1'b0; // [RULE11] [RULE15]
    if (ror_set)
      next_ror = 1'b1;
    ccf_clr = 8'h00;
    if (wr & (widx == `ATC_IDX_CCF) & !ffc)
      ccf_clr = pwdata[7:0]; // [RULE1] [RULE15]
    if (rd_res & ffc & !compare_enable[ridx])
      ccf_clr = 8'h01 << ridx; // [RULE2]
    if (wr_res & ffc & compare_enable[ridx])
      ccf_clr = 8'h01 << ridx; // [RULE3]
    ccf_set = 8'h00;
    if (conv_result.valid &
      (!compare_enable[conv_result.idx] | conv_result.cmp_hit))
      ccf_set = 8'h01 << conv_result.idx;
    next_ccf = (ccf & ~ccf_clr) | ccf_set;
    next_irqs = irqs;
    if (wr & (widx == `ATC_IDX_IRQS))
      next_irqs = irqs & ~pwdata[3:0];
    next_irqs = next_irqs | {ror, tor, cmp_irq_req, seq_irq_req};
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      {sync1, sync2, sync3} <= 36'h0;
      for (int i = 0; i < 6; i++)
        ctl[i] <= `ATC_CTL_RST;
      for (int i = 0; i < 8; i++)
        res[i] <= 16'h0000;
      {compare_enable, cmpht, ccf} <= 24'h0;
      {sequence_done_flag, tor, ror} <= 3'h0;
      cc <= 4'h0;
      irqs <= 4'h0;
      irqm <= `ATC_IRQM_RST;
      state <= ST_IDLE;
      {conv_start, conv_abort} <= 2'h0;
      ain_buf_en <= 8'h00;
      prdata <= 32'h0;
    end
    else if (ce)
    begin
      sync1 <= {trigger_inputs, ain_digital};
      sync2 <= sync1;
      sync3 <= sync2;
      ctl <= next_ctl;
      res <= next_res;
      {compare_enable, cmpht, ccf} <= {next_compare_enable, next_cmpht, next_ccf};
      {sequence_done_flag, tor, ror} <= {next_scf, next_tor, next_ror};
      cc <= next_cc;
      irqs <= next_irqs;
      irqm <= next_irqm;
      state <= next_state;
      {conv_start, conv_abort} <= {next_start, next_abort};
      ain_buf_en <= next_bufen;
      prdata <= next_prdata;
    end
  end
  property p_w1c_ccf;
    (wr && widx == `ATC_IDX_CCF && !ffc && !conv_result.valid)
      |=> (ccf & $past(pwdata[7:0])) == 8'h00;
  endproperty
  a_w1c_ccf: assert property (p_w1c_ccf) // [RULE1]
    else $error("completion flag not cleared by write one");
  property p_fast_read;
    (rd_res && ffc && !compare_enable[ridx] && !conv_result.valid)
      |=> !ccf[$past(ridx)];
  endproperty
  a_fast_read: assert property (p_fast_read) // [RULE2]
    else $error("fast clear on read failed");
  property p_fast_write;
    (wr_res && ffc && compare_enable[ridx] && !conv_result.valid)
      |=> !ccf[$past(ridx)];
  endproperty
  a_fast_write: assert property (p_fast_write) // [RULE3]
    else $error("fast clear on write failed");
  property p_level_start;
    (ce && ete && le && act_lvl && state == ST_IDLE && !wr)
      |=> conv_start && seq_busy;
  endproperty
  a_level_start: assert property (p_level_start) // [RULE4]
    else $error("active trigger level did not start a sequence");
  property p_seq_done;
    (ce && seq_done && seq_busy && ctl[2][`ATC_CTL2_SIE])
      |=> sequence_done_flag && seq_irq_req ##1 irqs[0];
  endproperty
  a_seq_done: assert property (p_seq_done) // [RULE8]
    else $error("sequence end did not raise flag and request");
  // a result or trigger edge in the same cycle sets again, set wins
  property p_ctl5_clear;
    (ctl5_wr && !seq_done && !conv_result.valid && !tor_set)
      |=> !sequence_done_flag && !tor && !ror;
  endproperty
  a_ctl5_clear: assert property (p_ctl5_clear) // [RULE9]
    else $error("control five write did not clear flags");
  property p_trig_overrun;
    (ce && ete && !le && act_edge && seq_busy) |=> tor;
  endproperty
  a_trig_overrun: assert property (p_trig_overrun) // [RULE10]
    else $error("extra edge during sequence not flagged");
  property p_abort_clear;
    (abort_wr && !conv_result.valid && !tor_set)
      |=> !tor && !ror && !seq_busy;
  endproperty
  a_abort_clear: assert property (p_abort_clear) // [RULE11]
    else $error("abort write did not clear overruns");
  property p_res_overrun;
    (ce && conv_result.valid && ccf[conv_result.idx]) |=> ror;
  endproperty
  a_res_overrun: assert property (p_res_overrun) // [RULE12]
    else $error("result overrun not flagged");
  property p_cc_keep;
    (wr_stat && !conv_result.valid && !next_start) |=> cc == $past(cc);
  endproperty
  a_cc_keep: assert property (p_cc_keep) // [RULE13]
    else $error("status write altered conversion counter");
  property p_zero_write;
    (wr_stat && !pwdata[`ATC_ST_SCF] && sequence_done_flag) |=> sequence_done_flag;
  endproperty
  a_zero_write: assert property (p_zero_write) // [RULE15]
    else $error("writing zero cleared sequence flag");
endmodule
`default_nettype wire

// >>> atc_conv_model.sv
// Converter model: answers each start with n_res results, then a done pulse; an n_res of zero gives neither.
// Assumes start and abort arrive as one-cycle pulses on clk.
`timescale 1ns/10ps
`default_nettype none
module atc_conv_model
  import atc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [3:0] n_res,
  input wire logic [1:0] gap,
  input wire logic cmp_hit,
  output atc_res_s conv_result,
  output logic seq_done
);
  logic [3:0] left;
  logic [3:0] nx;
  logic [1:0] w;
  logic fin;
  logic go;
  assign go = rst_n && !conv_abort && !conv_start && (left != 4'h0) &&
    (w == 2'h0);
  always @(posedge clk)
  begin
    // off-valid fields carry junk so nothing relies on stale data
    if (go)
      conv_result <= {1'b1, cmp_hit, nx[2:0], 16'($urandom)};
    else
      conv_result <= {1'b0, ~cmp_hit, ~nx[2:0], 16'($urandom)};
    seq_done <= fin;
    fin <= go && (left == 4'h1);
    if (!rst_n || conv_abort)
      left <= 4'h0;
    else if (conv_start)
    begin
      left <= n_res;
      nx <= 4'h0;
      w <= gap;
    end
    else if (left != 4'h0)
    begin
      if (w != 2'h0)
        w <= w - 2'h1;
      else
      begin
        nx <= nx + 4'h1;
        left <= left - 4'h1;
        w <= gap;
      end
    end
  end
endmodule
`default_nettype wire

// >>> adc_trigger_flag_control_test.sv
// Self-checking bench for the converter trigger and flag control block.
// Assumes atc_core with the converter model on its result side.
`timescale 1ns/10ps
`default_nettype none
`include "atc_map.svh"
module adc_trigger_flag_control_test
  import atc_pkg::*;
;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, buf_en, full;
  logic [31:0] pwdata, prdata, rd;
  atc_res_s res;
  logic seq_done, conv_start, conv_abort, seq_busy, sreq, creq, irq;
  logic pin, cmp_hit;
  logic [3:0] nres, n, src;
  logic [1:0] gap;
  int n_mismatch, n_checks, n_start, n_abort, cyc, s0;

  atc_core i_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_inputs({4{pin}}), .ain_digital({8{pin}}), .conv_result(res),
    .seq_done(seq_done), .conv_start(conv_start), .conv_abort(conv_abort),
    .seq_busy(seq_busy), .ain_buf_en(buf_en), .seq_irq_req(sreq),
    .cmp_irq_req(creq), .irq(irq));
  atc_conv_model i_model (.clk(clk), .rst_n(rst_n), .conv_start(conv_start),
    .conv_abort(conv_abort), .n_res(nres), .gap(gap), .cmp_hit(cmp_hit),
    .conv_result(res), .seq_done(seq_done));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (conv_start === 1'b1)
      n_start++;
    if (conv_abort === 1'b1)
      n_abort++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [31:0] e, input string s);
    apb(1'b0, idx, 32'h0);
    chk(s, e, rd);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic wait_seq;
    repeat (4) @(posedge clk);
    while (seq_busy !== 1'b0)
      @(posedge clk);
    settle;
  endtask

  initial
  begin
    {psel, penable, pwrite, cmp_hit, pin, rst_n} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    nres = 4'h1;
    gap = 2'h0;
    void'($urandom(32'h2DEE));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rchk(`ATC_IDX_CTL2, 32'h0, "ctl2 reset");
    rchk(`ATC_IDX_IRQM, 32'hF, "mask reset");
    rchk(`ATC_IDX_STAT0, 32'h0, "status reset");
    apb(1'b0, 6'h07, 32'h0);
    chk("unmapped err", 32'h1, err);
    n = 4'($urandom_range(8, 2));
    gap <= 2'($urandom);
    nres <= n;
    full = 8'((1 << n) - 1);
    wr(`ATC_IDX_CTL5, 32'h0);
    wait_seq;
    rchk(`ATC_IDX_STAT0, 32'h80 | n, "done and count");
    rchk(`ATC_IDX_CCF, full, "flags after seq");
    chk("seq req off", 32'h0, sreq);
    wr(`ATC_IDX_CTL2, 32'h02);
    settle;
    chk("seq req on", 32'h1, sreq);
    chk("irq on", 32'h1, irq);
    wr(`ATC_IDX_STAT0, 32'h7F);
    rchk(`ATC_IDX_STAT0, 32'h80 | n, "status keeps");
    wr(`ATC_IDX_CCF, 32'h0);
    wr(`ATC_IDX_CCF, 32'h1);
    rchk(`ATC_IDX_CCF, full & ~8'h01, "flag w1c");
    wr(`ATC_IDX_IRQM, 32'h0);
    settle;
    chk("irq masked", 32'h0, irq);
    wr(`ATC_IDX_STAT0, 32'h80);
    wr(`ATC_IDX_IRQS, 32'hF);
    rchk(`ATC_IDX_STAT0, 32'(n), "done w1c");
    chk("seq req clear", 32'h0, sreq);
    rchk(`ATC_IDX_IRQS, 32'h0, "irq status w1c");
    wr(`ATC_IDX_IRQM, 32'hF);
    wr(`ATC_IDX_CTL5, 32'h0);
    wait_seq;
    rchk(`ATC_IDX_STAT0, 32'h90 | n, "result overrun");
    s0 = n_abort;
    wr(`ATC_IDX_CTL0, 32'h0);
    rchk(`ATC_IDX_STAT0, 32'h80 | n, "abort clears");
    chk("abort pulse", 32'h1, n_abort == s0 + 1);
    wr(`ATC_IDX_CTL2, 32'h40);
    apb(1'b0, `ATC_IDX_RES + 6'h1, 32'h0);
    rchk(`ATC_IDX_CCF, full & ~8'h02, "fast read");
    rchk(`ATC_IDX_STAT0, 32'(n), "done fast read");
    wr(`ATC_IDX_COMPARE_ENABLE, 32'h1);
    wr(`ATC_IDX_CTL2, 32'h41);
    cmp_hit <= 1'b1;
    wr(`ATC_IDX_CTL5, 32'h0);
    wait_seq;
    chk("cmp req", 32'h1, creq);
    wr(`ATC_IDX_RES, 32'h0);
    settle;
    chk("cmp req gone", 32'h0, creq);
    rchk(`ATC_IDX_CCF, full & ~8'h01, "fast write");
    wr(`ATC_IDX_COMPARE_ENABLE, 32'h0);
    gap <= 2'h3;
    nres <= 4'h8;
    for (int m = 0; m < 4; m++)
    begin
      src = (m == 0) ? 4'h3 : 4'(8 + m);
      wr(`ATC_IDX_CTL2, 32'h0);
      pin <= ~m[0];
      wr(`ATC_IDX_CTL1, 32'(src));
      wr(`ATC_IDX_CTL2, 32'h4 | (m << 3));
      s0 = n_start;
      repeat (12) @(posedge clk);
      chk("idle trigger", s0, n_start);
      pin <= m[0];
      repeat (12) @(posedge clk);
      chk("trigger start", 32'h1, n_start > s0);
      if (m == 0)
        chk("buffer enable", 32'h08, buf_en);
      if (!m[1])
      begin
        pin <= ~m[0];
        repeat (2) @(posedge clk);
        pin <= m[0];
        repeat (6) @(posedge clk);
        apb(1'b0, `ATC_IDX_STAT0, 32'h0);
        chk("trigger overrun", 32'h20, rd & 32'h20);
        wr(`ATC_IDX_CTL5, 32'h0);
        apb(1'b0, `ATC_IDX_STAT0, 32'h0);
        chk("overrun cleared", 32'h0, rd & 32'h20);
      end
      pin <= ~m[0];
      wait_seq;
    end
    give_verdict;
  end
endmodule
`default_nettype wire
